//--- include/ars_pkg.sv
/*
 * ars_pkg: shared constants and types of the rotate/subtract/return
 * execution unit. Assumes a 32-bit APB slave with word-aligned registers.
 */
package ars_pkg;
	// ==================================================================
	// register map (byte addresses)
	localparam logic [7:0] ARS_INSTR_OFS = 8'h00;
	localparam logic [7:0] ARS_ACC_OFS   = 8'h04;
	localparam logic [7:0] ARS_FLAGS_OFS = 8'h08;
	localparam logic [7:0] ARS_PC_OFS    = 8'h0c;
	localparam logic [7:0] ARS_MADDR_OFS = 8'h10;
	localparam logic [7:0] ARS_MDATA_OFS = 8'h14;
	localparam logic [7:0] ARS_STACK_OFS = 8'h18;
	localparam logic [7:0] ARS_IRQ_OFS   = 8'h1c;
	localparam logic [7:0] ARS_STAT_OFS  = 8'h20;

	// ==================================================================
	// sizes and reset values
	localparam int ARS_PC_W    = 13;
	localparam int ARS_SP_W    = 3;
	localparam int ARS_MEM_D   = 256;
	localparam logic [ARS_PC_W-1:0] ARS_PC_RST    = 13'h0000;
	localparam logic [ARS_PC_W-1:0] ARS_IRQ_VEC   = 13'h0004;
	localparam logic [ARS_PC_W-1:0] ARS_PC_STEP   = 13'h0001;
	localparam logic [ARS_PC_W-1:0] ARS_PC_SKIP   = 13'h0002;
	localparam logic [7:0]          ARS_ACC_RST   = 8'h00;
	localparam logic [7:0]          ARS_ONE       = 8'h01;
	localparam logic [15:0]         ARS_CYC_ONE   = 16'h0001;

	// ==================================================================
	// opcodes, written into the instruction register
	typedef enum logic [4:0] {
		ARS_NO_OP_INSTR   = 5'h00, ARS_OR_ACC_MEM    = 5'h01,
		ARS_OR_ACC_IMM    = 5'h02, ARS_UNION_STORE_MEM = 5'h03,
		ARS_SUBROUTINE_EXIT = 5'h04, ARS_RETURN_LOAD_ACC = 5'h05,
		ARS_INTERRUPT_EXIT = 5'h06, ARS_ROTATE_LEFT   = 5'h07,
		ARS_ROTATE_LEFT_TO_ACC = 5'h08, ARS_ROTATE_LEFT_THRU_CY = 5'h09,
		ARS_ROTATE_LEFT_THRU_CY_ACC = 5'h0a, ARS_ROTATE_RIGHT = 5'h0b,
		ARS_ROTATE_RIGHT_TO_ACC = 5'h0c, ARS_ROTATE_RIGHT_THRU_CY = 5'h0d,
		ARS_ROTATE_RIGHT_THRU_CY_ACC = 5'h0e,
		ARS_SUBTRACT_WITH_BORROW = 5'h0f, ARS_SUBTRACT_BORROW_IMM = 5'h10,
		ARS_SUBTRACT_BORROW_TO_MEM = 5'h11, ARS_DECREMENT_SKIP_ZERO = 5'h12,
		ARS_DECREMENT_ACC_SKIP_ZERO = 5'h13
	} ars_op_type;

	// execution sequencer, gray along idle -> exec -> dummy, two bits change on dummy -> idle
	typedef enum logic [1:0] {
		ARS_IDLE  = 2'b00,
		ARS_EXEC  = 2'b01,
		ARS_DUMMY = 2'b11
	} ars_state_type;

	// instruction word: operand is memory address or immediate
	typedef struct packed {
		logic [7:0] operand;
		logic [2:0] pad;
		logic [4:0] opcode;
	} ars_instr_type;

	// status flags, bit 6 downward as read in the flags register
	typedef struct packed {
		logic irq_en;     // global_irq_enable
		logic chain_z;    // chained_zero_flag
		logic sign_b;     // signed_borrow_bit
		logic ovf;        // signed_range_flag
		logic aux;        // aux_nibble_flag
		logic zero;       // result_null_flag
		logic borrow_out; // borrow_out_bit (carry)
	} ars_flags_type;
	localparam ars_flags_type ARS_FLAGS_RST = 7'h00;
endpackage

//--- design/ars_exec_unit.sv
/*
 * ars_exec_unit: executes no-op, OR, returns, rotates, subtract with
 * borrow and decrement-and-skip on an accumulator, a 256-byte data
 * memory, a program counter stack and the status flags.
 * Assumes an APB master on the same clock; software issues one
 * instruction per write to the instruction register.
 */
// Notes on behaviour
// [RULE_01] no-op changes nothing and advances to the next instruction
// [RULE_02] OR into accumulator with memory or immediate, zero flag only
// [RULE_03] OR of accumulator and memory stored back to memory, zero only
// [RULE_04] subroutine exit pops program counter, flags untouched
// [RULE_05] return variant also loads accumulator with immediate, no flags
// [RULE_06] interrupt exit pops program counter and sets global irq enable; with one pending the code clears it and does not pop
// [RULE_07] pending interrupt is serviced before resuming the main program
// [RULE_08] rotate left in memory, bit 7 into bit 0, no flags
// [RULE_09] rotate left into accumulator, memory kept, no flags
// [RULE_10] rotate left through carry in memory, bit 7 to carry
// [RULE_11] rotate left through carry into accumulator, carry from bit 7
// [RULE_12] rotate right in memory, bit 0 into bit 7, no flags
// [RULE_13] rotate right into accumulator, memory kept, no flags
// [RULE_14] rotate right through carry in memory, bit 0 to carry
// [RULE_15] rotate right through carry into accumulator, carry from bit 0
// [RULE_16] accumulator minus memory minus inverted carry, six flags
// [RULE_17] carry cleared on negative result, set on zero or positive
// [RULE_18] immediate subtract with borrow into accumulator, six flags
// [RULE_19] subtract with borrow stored to memory, six flags
// [RULE_20] decrement memory, write back, skip next if zero, no flags
// [RULE_21] a skip inserts a dummy cycle, two instruction cycles
// [RULE_22] decrement into accumulator, memory kept, skip if zero
// [RULE_23] zero flag set when eight-bit result is zero, else cleared
`timescale 1ns/1ns
module ars_exec_unit
	import ars_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	// ==================================================================
	// storage
	logic [7:0]          mem_r [ARS_MEM_D];
	logic [ARS_PC_W-1:0] stack_r [1 << ARS_SP_W];
	logic [ARS_SP_W-1:0] sp_r;
	logic [ARS_PC_W-1:0] pc_r;
	logic [7:0]          acc_r;
	logic [7:0]          maddr_r;
	logic [15:0]         cyc_r;
	logic                pend_r;
	ars_flags_type       flags_r;
	ars_instr_type       instr_r;
	ars_state_type       state_r;

	// ==================================================================
	// bus decode: answer on the second access cycle
	logic wr_take;
	logic issue;
	assign wr_take = psel & penable & pready & pwrite;
	// instruction writes while busy are dropped
	assign issue = wr_take & (paddr == ARS_INSTR_OFS) & pstrb[0]
		& (state_r == ARS_IDLE);

	// pready pulses once per access, registered
	always_ff @(posedge clk) begin
		if (reset) begin
			pready <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
		end
	end

	// ==================================================================
	// operand fetch and arithmetic
	ars_op_type     op;
	logic [7:0]     mval;
	logic [7:0]     imm;
	logic [7:0]     sub_b;
	logic           bin;
	logic [8:0]     diff;
	logic [4:0]     ndiff;
	logic [7:0]     dec;
	assign op    = ars_op_type'(instr_r.opcode);
	assign imm   = instr_r.operand;
	assign mval  = mem_r[instr_r.operand];
	assign sub_b = (op == ARS_SUBTRACT_BORROW_IMM) ? imm : mval;
	// borrow in is the inverted carry
	assign bin   = ~flags_r.borrow_out;
	// [RULE_16] nine-bit difference
	assign diff  = {1'b0, acc_r} - {1'b0, sub_b} - {8'h00, bin};
	assign ndiff = {1'b0, acc_r[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, bin};
	assign dec   = mval - ARS_ONE;

	logic ov;
	assign ov = (acc_r[7] ^ sub_b[7]) & (acc_r[7] ^ diff[7]);

	// ==================================================================
	// result steering
	logic [7:0]          res;
	logic                to_mem;
	logic                to_acc;
	logic                set_z;
	logic                set_c;
	logic                new_c;
	logic                set_sub;
	logic                skip;
	always_comb begin
		res     = acc_r;
		to_mem  = 1'b0;
		to_acc  = 1'b0;
		set_z   = 1'b0;
		set_c   = 1'b0;
		new_c   = flags_r.borrow_out;
		set_sub = 1'b0;
		skip    = 1'b0;
		unique case (op)
			// [RULE_01] nothing stored
			ARS_NO_OP_INSTR: begin
			end
			// [RULE_02] or to accumulator
			ARS_OR_ACC_MEM: begin
				res = acc_r | mval; to_acc = 1'b1; set_z = 1'b1;
			end
			ARS_OR_ACC_IMM: begin
				res = acc_r | imm; to_acc = 1'b1; set_z = 1'b1;
			end
			// [RULE_03] or stored to memory
			ARS_UNION_STORE_MEM: begin
				res = acc_r | mval; to_mem = 1'b1; set_z = 1'b1;
			end
			// returns handled by the pc logic
			ARS_SUBROUTINE_EXIT, ARS_INTERRUPT_EXIT: begin
			end
			// [RULE_05] immediate to accumulator
			ARS_RETURN_LOAD_ACC: begin
				res = imm; to_acc = 1'b1;
			end
			// [RULE_08] left rotate in memory
			ARS_ROTATE_LEFT: begin
				res = {mval[6:0], mval[7]}; to_mem = 1'b1;
			end
			// [RULE_09] left rotate to accumulator
			ARS_ROTATE_LEFT_TO_ACC: begin
				res = {mval[6:0], mval[7]}; to_acc = 1'b1;
			end
			// [RULE_10] left through carry
			ARS_ROTATE_LEFT_THRU_CY: begin
				res = {mval[6:0], flags_r.borrow_out}; to_mem = 1'b1;
				set_c = 1'b1; new_c = mval[7];
			end
			// [RULE_11] left through carry to accumulator
			ARS_ROTATE_LEFT_THRU_CY_ACC: begin
				res = {mval[6:0], flags_r.borrow_out}; to_acc = 1'b1;
				set_c = 1'b1; new_c = mval[7];
			end
			// [RULE_12] right rotate in memory
			ARS_ROTATE_RIGHT: begin
				res = {mval[0], mval[7:1]}; to_mem = 1'b1;
			end
			// [RULE_13] right rotate to accumulator
			ARS_ROTATE_RIGHT_TO_ACC: begin
				res = {mval[0], mval[7:1]}; to_acc = 1'b1;
			end
			// [RULE_14] right through carry
			ARS_ROTATE_RIGHT_THRU_CY: begin
				res = {flags_r.borrow_out, mval[7:1]}; to_mem = 1'b1;
				set_c = 1'b1; new_c = mval[0];
			end
			// [RULE_15] right through carry to accumulator
			ARS_ROTATE_RIGHT_THRU_CY_ACC: begin
				res = {flags_r.borrow_out, mval[7:1]}; to_acc = 1'b1;
				set_c = 1'b1; new_c = mval[0];
			end
			// [RULE_16] [RULE_18] subtract to accumulator
			ARS_SUBTRACT_WITH_BORROW, ARS_SUBTRACT_BORROW_IMM: begin
				res = diff[7:0]; to_acc = 1'b1; set_sub = 1'b1;
			end
			// [RULE_19] subtract to memory
			ARS_SUBTRACT_BORROW_TO_MEM: begin
				res = diff[7:0]; to_mem = 1'b1; set_sub = 1'b1;
			end
			// [RULE_20] decrement memory, skip on zero
			ARS_DECREMENT_SKIP_ZERO: begin
				res = dec; to_mem = 1'b1; skip = (dec == ARS_ACC_RST);
			end
			// [RULE_22] decrement to accumulator, skip on zero
			ARS_DECREMENT_ACC_SKIP_ZERO: begin
				res = dec; to_acc = 1'b1; skip = (dec == ARS_ACC_RST);
			end
			// unknown codes behave as no-op
			default: begin
			end
		endcase
	end

	logic exec;
	assign exec = (state_r == ARS_EXEC);

	// ==================================================================
	// sequencer: one cycle, or two when a skip needs the dummy cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= ARS_IDLE;
		end else begin
			unique case (state_r)
				ARS_IDLE:  state_r <= issue ? ARS_EXEC : ARS_IDLE;
				// [RULE_21] dummy fetch cycle after a skip
				ARS_EXEC:  state_r <= skip ? ARS_DUMMY : ARS_IDLE;
				ARS_DUMMY: state_r <= ARS_IDLE;
				default:   state_r <= ARS_IDLE;
			endcase
		end
	end

	// instruction cycle counter, counts exec and dummy cycles
	always_ff @(posedge clk) begin
		if (reset) begin
			cyc_r <= 16'h0000;
		end else if (state_r != ARS_IDLE) begin
			cyc_r <= cyc_r + ARS_CYC_ONE;
		end
	end

	// instruction register
	always_ff @(posedge clk) begin
		if (reset) begin
			instr_r <= '0;
		end else if (issue) begin
			instr_r <= ars_instr_type'(pwdata[15:0]);
		end
	end

	// ==================================================================
	// accumulator: execution wins over a software write in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			acc_r <= ARS_ACC_RST;
		end else if (exec & to_acc) begin
			acc_r <= res;
		end else if (wr_take & (paddr == ARS_ACC_OFS) & pstrb[0]) begin
			acc_r <= pwdata[7:0];
		end
	end

	// data memory, no reset so it maps onto plain ram
	always_ff @(posedge clk) begin
		if (exec & to_mem) begin
			mem_r[instr_r.operand] <= res;
		end else if (wr_take & (paddr == ARS_MDATA_OFS) & pstrb[0]) begin
			mem_r[maddr_r] <= pwdata[7:0];
		end
	end

	// memory window address
	always_ff @(posedge clk) begin
		if (reset) begin
			maddr_r <= 8'h00;
		end else if (wr_take & (paddr == ARS_MADDR_OFS) & pstrb[0]) begin
			maddr_r <= pwdata[7:0];
		end
	end

	// ==================================================================
	// flags
	logic ret_irq;
	assign ret_irq = exec & (op == ARS_INTERRUPT_EXIT);
	always_ff @(posedge clk) begin
		if (reset) begin
			flags_r <= ARS_FLAGS_RST;
		end else if (exec) begin
			// [RULE_23] zero from the eight-bit result
			if (set_z | set_sub) begin
				flags_r.zero <= (res == ARS_ACC_RST);
			end
			if (set_c) begin
				flags_r.borrow_out <= new_c;
			end
			if (set_sub) begin
				// [RULE_17] carry is the inverted borrow
				flags_r.borrow_out <= ~diff[8];
				flags_r.aux        <= ~ndiff[4];
				flags_r.ovf        <= ov;
				flags_r.sign_b     <= diff[7] ^ ov;
				// chained zero keeps the zero of earlier bytes
				flags_r.chain_z    <= flags_r.chain_z
					& (res == ARS_ACC_RST);
			end
			// [RULE_06] re-enable unless the pending entry clears it
			if (ret_irq) begin
				flags_r.irq_en <= ~pend_r;
			end
		end else if (wr_take & (paddr == ARS_FLAGS_OFS) & pstrb[0]) begin
			flags_r <= ars_flags_type'(pwdata[6:0]);
		end
	end

	// pending interrupt: a software set wins over the service clear
	logic pend_set;
	assign pend_set = wr_take & (paddr == ARS_IRQ_OFS) & pstrb[0]
		& pwdata[0];
	always_ff @(posedge clk) begin
		if (reset) begin
			pend_r <= 1'b0;
		end else begin
			pend_r <= pend_set | (pend_r & ~ret_irq);
		end
	end

	// ==================================================================
	// program counter and stack
	logic [ARS_SP_W-1:0] sp_top;
	logic                pop;
	logic                push_sw;
	assign sp_top  = sp_r - 3'd1;
	// a pending interrupt keeps the return address stacked
	assign pop     = exec & ((op == ARS_SUBROUTINE_EXIT)
		| (op == ARS_RETURN_LOAD_ACC) | (ret_irq & ~pend_r));
	assign push_sw = wr_take & (paddr == ARS_STACK_OFS) & pstrb[0];

	always_ff @(posedge clk) begin
		if (reset) begin
			pc_r <= ARS_PC_RST;
		end else if (exec) begin
			if (ret_irq & pend_r) begin
				// [RULE_07] enter the pending routine first
				pc_r <= ARS_IRQ_VEC;
			end else if (pop) begin
				// [RULE_04] continue at the restored address
				pc_r <= stack_r[sp_top];
			end else if (skip) begin
				// [RULE_20] skip the following instruction
				pc_r <= pc_r + ARS_PC_SKIP;
			end else begin
				// [RULE_01] plain advance
				pc_r <= pc_r + ARS_PC_STEP;
			end
		end else if (wr_take & (paddr == ARS_PC_OFS) & pstrb[0]) begin
			pc_r <= pwdata[ARS_PC_W-1:0];
		end
	end

	// stack wraps silently on overflow or underflow
	always_ff @(posedge clk) begin
		if (reset) begin
			sp_r <= '0;
		end else if (pop) begin
			sp_r <= sp_top;
		end else if (push_sw & ~exec) begin
			sp_r <= sp_r + 3'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (push_sw & ~exec) begin
			stack_r[sp_r] <= pwdata[ARS_PC_W-1:0];
		end
	end

	// ==================================================================
	// read data and error, registered with pready
	logic [31:0] rdata;
	logic        hit;
	always_comb begin
		rdata = 32'h0000_0000;
		hit   = 1'b1;
		unique case (paddr)
			ARS_INSTR_OFS: rdata = {16'h0000, instr_r};
			ARS_ACC_OFS:   rdata = {24'h000000, acc_r};
			ARS_FLAGS_OFS: rdata = {25'h0000000, flags_r};
			ARS_PC_OFS:    rdata = {19'h00000, pc_r};
			ARS_MADDR_OFS: rdata = {24'h000000, maddr_r};
			ARS_MDATA_OFS: rdata = {24'h000000, mem_r[maddr_r]};
			ARS_STACK_OFS: rdata = {29'h00000000, sp_r};
			ARS_IRQ_OFS:   rdata = {31'h00000000, pend_r};
			ARS_STAT_OFS:  rdata = {cyc_r, 14'h0000, state_r};
			default:       hit   = 1'b0;
		endcase
	end

	// data and error are set up while pready is still low
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel & penable & ~pready) begin
			prdata  <= pwrite ? 32'h0000_0000 : rdata;
			pslverr <= ~hit;
		end else begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end
endmodule // ars_exec_unit

//--- tb/ars_exec_unit_asserts.sv
/*
 * ars_exec_unit_asserts: bus-level checks of the execution unit.
 * Assumes it is bound to ars_exec_unit and sees only its ports.
 */
`timescale 1ns/1ns
module ars_exec_unit_asserts
	import ars_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	// one clock domain, so one default clocking and reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// ==================================================================
	// handshake: exactly one wait state, one-cycle answer
	AST_READY_WAIT: assert property ( // bus wait
		$rose(penable) && psel |-> !pready ##1 pready)
		else $error("ready not on second access cycle");
	AST_READY_ONE: assert property ( // bus pulse
		pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_READY_ACCESS: assert property ( // bus phase
		pready |-> psel && penable)
		else $error("ready outside access phase");
	AST_ERR_ONLY_READY: assert property ( // bus error
		pslverr |-> pready)
		else $error("error without ready");
	AST_RDATA_QUIET: assert property ( // bus data
		!pready |-> prdata == 32'h0)
		else $error("read data outside ready cycle");
	AST_UNMAPPED: assert property ( // bus map
		pready && paddr > ARS_STAT_OFS |-> pslverr)
		else $error("unmapped access not refused");
	AST_MAPPED_OK: assert property ( // bus map
		pready && paddr <= ARS_STAT_OFS && paddr[1:0] == 2'b00
		|-> !pslverr)
		else $error("mapped access refused");

	// ==================================================================
	// register widths and state encoding
	AST_ACC_WIDTH: assert property (
		pready && !pwrite && paddr == ARS_ACC_OFS
		|-> prdata[31:8] == 24'h0)
		else $error("accumulator upper bits set");
	AST_FLAGS_WIDTH: assert property (
		pready && !pwrite && paddr == ARS_FLAGS_OFS
		|-> prdata[31:7] == 25'h0)
		else $error("flags upper bits set");
	AST_PC_WIDTH: assert property (
		pready && !pwrite && paddr == ARS_PC_OFS
		|-> prdata[31:13] == 19'h0)
		else $error("program counter upper bits set");
	AST_STATE_CODE: assert property (
		pready && !pwrite && paddr == ARS_STAT_OFS
		|-> prdata[1:0] != 2'b10)
		else $error("sequencer state code illegal");
endmodule // ars_exec_unit_asserts

bind ars_exec_unit ars_exec_unit_asserts chk_u (
	.clk, .reset, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .pslverr
);

//--- tb/ars_exec_unit_tb_top.sv
/*
 * ars_exec_unit_tb_top: self-checking bench of the execution unit.
 * Assumes an APB slave that answers within a bounded number of cycles.
 */
`timescale 1ns/1ns
module ars_exec_unit_tb_top
	import ars_pkg::*;
;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hf;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] q;
	logic        last_err;
	logic [7:0]  r_acc;
	logic [7:0]  r_mem;
	logic [6:0]  r_flg;
	logic [12:0] r_pc;
	logic [15:0] r_cyc;
	int          errors = 0;
	int          check_count = 0;
	int          cyc = 0;

	ars_exec_unit dut_u (
		.clk, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr
	);

	// ==================================================================
	// clock and hang guard
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			results();
		end
	end

	// ==================================================================
	// bus master: idle cycle after each transfer avoids double drives
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q        = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk(input string n, input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s exp %h got %h", n, exp, got);
		end
	endtask

	// load state, optionally push a return address, run one opcode
	task automatic exe(input logic [4:0] op, input logic [7:0] opd, a, m,
		input logic [6:0] f, input logic [12:0] stk, input logic irq);
		bus(1'b1, ARS_ACC_OFS, {24'h0, a});
		bus(1'b1, ARS_FLAGS_OFS, {25'h0, f});
		if (stk != 13'h0) begin
			bus(1'b1, ARS_PC_OFS, {19'h0, stk});
			bus(1'b1, ARS_STACK_OFS, {19'h0, stk});
		end
		bus(1'b1, ARS_PC_OFS, 32'h100);
		bus(1'b1, ARS_MADDR_OFS, {24'h0, opd});
		bus(1'b1, ARS_MDATA_OFS, {24'h0, m});
		if (irq)
			bus(1'b1, ARS_IRQ_OFS, 32'h1);
		bus(1'b1, ARS_INSTR_OFS, {16'h0, opd, 3'h0, op});
		q = 32'h1;
		while (q[1:0] != 2'b00)
			bus(1'b0, ARS_STAT_OFS, 32'h0);
		r_cyc = q[31:16];
		bus(1'b0, ARS_ACC_OFS, 32'h0);
		r_acc = q[7:0];
		bus(1'b0, ARS_FLAGS_OFS, 32'h0);
		r_flg = q[6:0];
		bus(1'b0, ARS_MDATA_OFS, 32'h0);
		r_mem = q[7:0];
		bus(1'b0, ARS_PC_OFS, 32'h0);
		r_pc = q[12:0];
	endtask

	// ==================================================================
	// scenarios
	task automatic t_logic();
		exe(ARS_NO_OP_INSTR, 8'h21, 8'h5a, 8'ha5, 7'h15, 13'h0, 1'b0);
		chk("nop acc", r_acc, 8'h5a);
		chk("nop mem", r_mem, 8'ha5);
		chk("nop flg", r_flg, 7'h15);
		chk("nop pc", r_pc, 13'h101);
		exe(ARS_OR_ACC_MEM, 8'h22, 8'h0c, 8'h30, 7'h3f, 13'h0, 1'b0);
		chk("or acc", r_acc, 8'h3c);
		chk("or flg", r_flg, 7'h3d);
		exe(ARS_OR_ACC_IMM, 8'h00, 8'h00, 8'h55, 7'h3d, 13'h0, 1'b0);
		chk("ori acc", r_acc, 8'h00);
		chk("ori flg", r_flg, 7'h3f);
		exe(ARS_UNION_STORE_MEM, 8'h23, 8'h81, 8'h42, 7'h3f, 13'h0, 1'b0);
		chk("orm mem", r_mem, 8'hc3);
		chk("orm acc", r_acc, 8'h81);
		chk("orm flg", r_flg, 7'h3d);
		bus(1'b0, 8'h40, 32'h0);
		chk("unmapped err", last_err, 1'b1); // bus error
	endtask

	task automatic t_rot();
		logic [7:0] m;
		logic [7:0] e;
		logic       c;
		m = 8'h96;
		for (int i = 0; i < 8; i++) begin
			c = i[2];
			case (i[2:1])
				2'd0: e = {m[6:0], m[7]};
				2'd1: e = {m[6:0], c};
				2'd2: e = {m[0], m[7:1]};
				default: e = {c, m[7:1]};
			endcase
			exe(5'h07 + 5'(i), 8'h40, 8'h3c, m, {6'h15, c}, 13'h0, 1'b0);
			chk("rot acc", r_acc, i[0] ? e : 8'h3c);
			chk("rot mem", r_mem, i[0] ? m : e);
			chk("rot flg", r_flg, {6'h15,
				i[1] ? (i[2] ? m[0] : m[7]) : c});
		end
	endtask

	task automatic t_sbc();
		logic [31:0] av;
		logic [31:0] mv;
		logic [7:0]  a;
		logic [7:0]  m;
		logic        c;
		logic [8:0]  r;
		logic [4:0]  n;
		logic        ov;
		int          op;
		av = 32'h05803050;
		mv = 32'h04013030;
		for (int k = 0; k < 12; k++) begin
			op = k / 4;
			a = av[8*(k%4) +: 8];
			m = mv[8*(k%4) +: 8];
			c = ~k[0];
			r = {1'b0, a} - {1'b0, m} - {8'h0, ~c};
			n = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
			ov = (a[7] ^ m[7]) & (r[7] ^ a[7]);
			exe(5'h0f + 5'(op), m, a, m, {1'b0, k[1], 4'h0, c}, 13'h0, 1'b0);
			chk("sbc acc", r_acc, op == 2 ? a : r[7:0]);
			chk("sbc mem", r_mem, op == 2 ? r[7:0] : m);
			chk("sbc flg", r_flg[5:0],
				{k[1] & (r[7:0] == 8'h0), r[7] ^ ov, ov, ~n[4],
				r[7:0] == 8'h0, ~r[8]});
		end
	endtask

	task automatic t_dsz();
		logic [7:0] m;
		logic [7:0] d;
		logic [15:0] p;
		for (int k = 0; k < 4; k++) begin
			m = 8'(32'h00010201 >> (8 * k));
			d = m - 8'h01;
			p = r_cyc;
			exe(k[1] ? ARS_DECREMENT_ACC_SKIP_ZERO : ARS_DECREMENT_SKIP_ZERO,
				8'h50, 8'h11, m, 7'h15, 13'h0, 1'b0);
			chk("dsz acc", r_acc, k[1] ? d : 8'h11);
			chk("dsz mem", r_mem, k[1] ? m : d);
			chk("dsz pc", r_pc, d == 8'h0 ? 13'h102 : 13'h101);
			chk("dsz cyc", 16'(r_cyc - p), d == 8'h0 ? 16'h2 : 16'h1);
			chk("dsz flg", r_flg, 7'h15);
		end
	endtask

	task automatic t_ret();
		exe(ARS_SUBROUTINE_EXIT, 8'h77, 8'h11, 8'h00, 7'h15, 13'habc, 1'b0);
		chk("ret pc", r_pc, 13'habc);
		chk("ret flg", r_flg, 7'h15);
		exe(ARS_RETURN_LOAD_ACC, 8'h77, 8'h11, 8'h00, 7'h15, 13'habc, 1'b0);
		chk("retl pc", r_pc, 13'habc);
		chk("retl acc", r_acc, 8'h77);
		chk("retl flg", r_flg, 7'h15);
		exe(ARS_INTERRUPT_EXIT, 8'h00, 8'h11, 8'h00, 7'h15, 13'habc, 1'b0);
		chk("interrupt_exit pc", r_pc, 13'habc);
		chk("interrupt_exit flg", r_flg, 7'h55);
		exe(ARS_INTERRUPT_EXIT, 8'h00, 8'h11, 8'h00, 7'h15, 13'h123, 1'b1);
		chk("interrupt_exit vec", r_pc, ARS_IRQ_VEC);
		bus(1'b0, ARS_IRQ_OFS, 32'h0);
		chk("interrupt_exit pend", q[0], 1'b0);
		exe(ARS_INTERRUPT_EXIT, 8'h00, 8'h11, 8'h00, 7'h15, 13'h0, 1'b0);
		chk("interrupt_exit main", r_pc, 13'h123);
		chk("interrupt_exit en", r_flg, 7'h55);
	endtask

	// ==================================================================
	// verdict and main sequence
	task automatic results();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		t_logic();
		t_rot();
		t_sbc();
		t_dsz();
		t_ret();
		results();
	end
endmodule // ars_exec_unit_tb_top
